/* logic/tcc_map.vh */
// register offsets, field positions and reset values of the timer slice
`ifndef TCC_MAP_VH
`define TCC_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define TCC_OFF_MODE 8'h18
`define TCC_OFF_ENABLE 8'h20
`define TCC_OFF_COUNT 8'h24
`define TCC_OFF_DIV 8'h28
`define TCC_OFF_RELOAD 8'h2C
`define TCC_OFF_CAP1 8'h30
`define TCC_OFF_CAP2 8'h34

// ****************************************************************
// field positions
// ****************************************************************
`define TCC_CH1_DIR_LSB 0
`define TCC_CH1_DIV_LSB 2
`define TCC_CH2_DIR_LSB 8
`define TCC_CH2_DIV_LSB 10
`define TCC_CH1_EN_BIT 0
`define TCC_CH1_POL_BIT 1
`define TCC_CH2_EN_BIT 4
`define TCC_CH2_POL_BIT 5

// ****************************************************************
// writable masks and reset values
// ****************************************************************
`define TCC_MODE_MASK 16'h0F0F
`define TCC_ENABLE_MASK 16'h0033
`define TCC_RST_ZERO 16'h0000
`define TCC_RST_RELOAD 16'hFFFF
`define TCC_DIR_OUTPUT 2'h0
`define TCC_DIR_PIN_ONE 2'h1

`endif

/* logic/tcc_sync.v */
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/100ps
module tcc_sync (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire pin_i,
	output wire level_o
);
	reg meta_r;
	reg s2_r;
	reg s3_r;
	reg level_r;

	// a change counts only once the second and third stage agree
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			meta_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_r <= 1'b0;
		end else begin
			meta_r <= pin_i;
			s2_r <= meta_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_r <= s3_r;
			end
		end
	end

	assign level_o = level_r;
endmodule

/* logic/tcc_timer.v */
// two-channel timer slice: channel config, counter, prescaler, apb slave
`timescale 1ns/100ps
`include "tcc_map.vh"

// Behaviour
// - ch2 direction field [9:8] = 00 makes channel 2 an output.
// - direction code 01 makes channel an input fed from input pin one.
// - direction code 10 or 11 makes channel an input fed from pin two.
// - ch1 direction field at mode bits [1:0], read/write, resets zero.
// - ch1 capture divider at mode bits [3:2], read/write, resets zero.
// - capture divider 00/01/10/11 captures every 1/2/4/8 edges.
// - capture event count clears while the channel enable bit is zero.
// - enable register bit 5 is channel 2 polarity, read/write, reset zero.
// - channel 2 output driven only while enable bit 4 is set.
// - enable register bit 1 is channel 1 polarity, read/write, reset zero.
// - channel 1 output driven only while enable bit 0 is set.
// - counter register reads live count, write loads it, resets zero.
// - counter clocks at input rate divided by divider value plus one.
// - counter wraps at reload value (reset all ones); stops when zero.
module tcc_timer (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire timer_input_one_i,
	input wire timer_input_two_i,
	output wire ch1_out_o,
	output wire ch1_out_en_o,
	output wire ch2_out_o,
	output wire ch2_out_en_o
);

	// ****************************************************************
	// functions
	// ****************************************************************

	// pick the capture source for a channel from its direction code
	function f_src;
		input [1:0] dir;
		input lvl_one;
		input lvl_two;
		begin
			if (dir == `TCC_DIR_PIN_ONE) begin
				f_src = lvl_one;
			end else begin
				f_src = lvl_two;
			end
		end
	endfunction

	// true when the edge count has reached the divider's terminal value
	function f_div_hit;
		input [1:0] div;
		input [2:0] cnt;
		begin
			case (div)
			2'h0: f_div_hit = 1'b1;
			2'h1: f_div_hit = (cnt[0] == 1'b1);
			2'h2: f_div_hit = (cnt[1:0] == 2'h3);
			2'h3: f_div_hit = (cnt == 3'h7);
			default: f_div_hit = 1'b1;
			endcase
		end
	endfunction

	// address decode, shared by read and write paths
	function f_mapped;
		input [7:0] addr;
		begin
			case (addr)
			`TCC_OFF_MODE, `TCC_OFF_ENABLE, `TCC_OFF_COUNT,
			`TCC_OFF_DIV, `TCC_OFF_RELOAD, `TCC_OFF_CAP1,
			`TCC_OFF_CAP2: f_mapped = 1'b1;
			default: f_mapped = 1'b0;
			endcase
		end
	endfunction

	// ****************************************************************
	// registers
	// ****************************************************************
	reg [15:0] mode_r;
	reg [15:0] channel_enable_polarity_r;
	reg [15:0] counter_value_r;
	reg [15:0] counter_clock_divider_r;
	reg [15:0] reload_value_r;
	reg [15:0] psc_cnt_r;
	reg [31:0] prdata_r;
	reg pready_r;
	reg pslverr_r;

	wire [1:0] tin_lvl;
	wire [31:0] cap_val_w;
	wire [1:0] out_w;
	wire [1:0] out_en_w;

	wire setup_w;
	wire wr_w;
	wire tick_w;
	wire run_w;
	wire wrap_w;
	wire [3:0] dir_all;
	wire [3:0] div_all;
	wire [1:0] en_all;
	wire [1:0] pol_all;

	assign setup_w = psel_i & ~penable_i;
	// a write takes effect only at the edge that completes the access
	assign wr_w = psel_i & penable_i & pwrite_i & pready_r;

	assign dir_all = {mode_r[`TCC_CH2_DIR_LSB+1:`TCC_CH2_DIR_LSB],
		mode_r[`TCC_CH1_DIR_LSB+1:`TCC_CH1_DIR_LSB]};
	assign div_all = {mode_r[`TCC_CH2_DIV_LSB+1:`TCC_CH2_DIV_LSB],
		mode_r[`TCC_CH1_DIV_LSB+1:`TCC_CH1_DIV_LSB]};
	assign en_all = {channel_enable_polarity_r[`TCC_CH2_EN_BIT],
		channel_enable_polarity_r[`TCC_CH1_EN_BIT]};
	assign pol_all = {channel_enable_polarity_r[`TCC_CH2_POL_BIT],
		channel_enable_polarity_r[`TCC_CH1_POL_BIT]};

	// ****************************************************************
	// pin input synchronisers
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_sync
			tcc_sync u_sync (
				.clk_sys_i(clk_sys_i),
				.sys_rst_i(sys_rst_i),
				.pin_i(g == 0 ? timer_input_one_i : timer_input_two_i),
				.level_o(tin_lvl[g])
			);
		end
	endgenerate

	// ****************************************************************
	// apb slave and software registers
	// ****************************************************************

	// pready is registered: the access phase always lasts one cycle
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (setup_w) begin
			pready_r <= 1'b1;
			pslverr_r <= ~f_mapped(paddr_i);
			prdata_r <= 32'h0000_0000;
			if (!pwrite_i) begin
				case (paddr_i)
				`TCC_OFF_MODE: prdata_r[15:0] <= mode_r;
				`TCC_OFF_ENABLE: begin
					prdata_r[15:0] <= channel_enable_polarity_r;
				end
				`TCC_OFF_COUNT: prdata_r[15:0] <= counter_value_r;
				`TCC_OFF_DIV: prdata_r[15:0] <= counter_clock_divider_r;
				`TCC_OFF_RELOAD: prdata_r[15:0] <= reload_value_r;
				`TCC_OFF_CAP1: prdata_r[15:0] <= cap_val_w[15:0];
				`TCC_OFF_CAP2: prdata_r[15:0] <= cap_val_w[31:16];
				default: prdata_r <= 32'h0000_0000;
				endcase
			end
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			mode_r <= `TCC_RST_ZERO;
			channel_enable_polarity_r <= `TCC_RST_ZERO;
			counter_clock_divider_r <= `TCC_RST_ZERO;
			reload_value_r <= `TCC_RST_RELOAD;
		end else if (wr_w) begin
			case (paddr_i)
			`TCC_OFF_MODE: mode_r <= pwdata_i[15:0] & `TCC_MODE_MASK;
			`TCC_OFF_ENABLE: begin
				// reserved positions stay zero
				channel_enable_polarity_r <=
					pwdata_i[15:0] & `TCC_ENABLE_MASK;
			end
			`TCC_OFF_DIV: counter_clock_divider_r <= pwdata_i[15:0];
			`TCC_OFF_RELOAD: reload_value_r <= pwdata_i[15:0];
			default: mode_r <= mode_r;
			endcase
		end
	end

	// ****************************************************************
	// prescaler and counter
	// ****************************************************************
	assign tick_w = (psc_cnt_r == counter_clock_divider_r);
	assign run_w = (reload_value_r != 16'h0000);
	assign wrap_w = tick_w & run_w & (counter_value_r >= reload_value_r);

	// a divider change is seen at the next terminal count or compare
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			psc_cnt_r <= 16'h0000;
		end else if (tick_w || psc_cnt_r > counter_clock_divider_r) begin
			psc_cnt_r <= 16'h0000;
		end else begin
			psc_cnt_r <= psc_cnt_r + 16'h0001;
		end
	end

	// a software write to the counter wins over a tick in the same cycle
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			counter_value_r <= `TCC_RST_ZERO;
		end else if (wr_w && paddr_i == `TCC_OFF_COUNT) begin
			counter_value_r <= pwdata_i[15:0];
		end else if (wrap_w) begin
			counter_value_r <= 16'h0000;
		end else if (tick_w && run_w) begin
			counter_value_r <= counter_value_r + 16'h0001;
		end
	end

	// ****************************************************************
	// capture / output channels
	// ****************************************************************
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_ch
			reg src_prev_r;
			reg [2:0] evt_cnt_r;
			reg [15:0] cap_r;
			reg toggle_r;
			reg out_r;
			reg out_en_r;
			wire [1:0] dir;
			wire [1:0] div;
			wire src;
			wire is_out;
			wire edge_seen;

			assign dir = dir_all[2*g+1:2*g];
			assign div = div_all[2*g+1:2*g];
			assign src = f_src(dir, tin_lvl[0], tin_lvl[1]);
			assign is_out = (dir == `TCC_DIR_OUTPUT);
			// polarity 0 captures rising edges, 1 falling edges
			assign edge_seen = !is_out &&
				((src & ~src_prev_r) ^ (pol_all[g] & (src ^ src_prev_r)));

			always @(posedge clk_sys_i) begin
				if (sys_rst_i) begin
					src_prev_r <= 1'b0;
					evt_cnt_r <= 3'h0;
					cap_r <= 16'h0000;
				end else begin
					src_prev_r <= src;
					if (!en_all[g]) begin
						evt_cnt_r <= 3'h0;
					end else if (edge_seen) begin
						if (f_div_hit(div, evt_cnt_r)) begin
							evt_cnt_r <= 3'h0;
							cap_r <= counter_value_r;
						end else begin
							evt_cnt_r <= evt_cnt_r + 3'h1;
						end
					end
				end
			end

			// output waveform toggles on each counter wrap
			always @(posedge clk_sys_i) begin
				if (sys_rst_i) begin
					toggle_r <= 1'b0;
					out_r <= 1'b0;
					out_en_r <= 1'b0;
				end else begin
					if (wrap_w) begin
						toggle_r <= ~toggle_r;
					end
					out_en_r <= is_out & en_all[g];
					if (is_out && en_all[g]) begin
						out_r <= toggle_r ^ pol_all[g];
					end else begin
						out_r <= 1'b0;
					end
				end
			end

			assign cap_val_w[16*g+15:16*g] = cap_r;
			assign out_w[g] = out_r;
			assign out_en_w[g] = out_en_r;
		end
	endgenerate

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign prdata_o = prdata_r;
	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign ch1_out_o = out_w[0];
	assign ch1_out_en_o = out_en_w[0];
	assign ch2_out_o = out_w[1];
	assign ch2_out_en_o = out_en_w[1];

endmodule

/* bench/tcc_timer_monitor.sv */
// checker for the timer slice register bus and channel enables
`timescale 1ns/100ps
module tcc_timer_monitor (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	input wire ch1_out_en_o,
	input wire ch2_out_en_o
);
	wire setup = psel_i && !penable_i;
	wire wr_done = psel_i && penable_i && pwrite_i && pready_o;
	wire mapped = paddr_i inside {8'h18, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
		8'h34};
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);
	// ****************
	// bus properties
	// ****************
	a_ready_next: assert property (setup |=> pready_o)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_ready_access: assert property (
		pready_o |-> psel_i && penable_i)
		else $error("ready outside access");
	a_err_decode: assert property (
		setup |=> pslverr_o == !$past(mapped))
		else $error("error flag does not match decode");
	a_err_zero: assert property (
		pslverr_o && !pwrite_i |-> prdata_o == 0)
		else $error("refused read returns data");
	a_upper_zero: assert property (
		pready_o |-> prdata_o[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_rsv_zero: assert property (
		pready_o && !pwrite_i && paddr_i == 8'h20
		|-> prdata_o[15:6] == 10'h000 && prdata_o[3:2] == 2'h0)
		else $error("reserved enable bits read nonzero");
	// enables move only as a result of a register write
	a_en1_cause: assert property (
		$changed(ch1_out_en_o) |-> $past(wr_done, 2))
		else $error("channel 1 enable moved without write");
	a_en2_cause: assert property (
		$changed(ch2_out_en_o) |-> $past(wr_done, 2))
		else $error("channel 2 enable moved without write");
endmodule

bind tcc_timer tcc_timer_monitor mon (
	.clk_sys_i,
	.sys_rst_i,
	.psel_i,
	.penable_i,
	.pwrite_i,
	.paddr_i,
	.prdata_o,
	.pready_o,
	.pslverr_o,
	.ch1_out_en_o,
	.ch2_out_en_o
);

/* bench/tcc_timer_test.sv */
// self-checking bench for the timer slice
`timescale 1ns/100ps
module tcc_timer_test;
	typedef struct {
		logic w;
		logic e;
		logic [31:0] lo;
		logic [31:0] hi;
	} tcc_note_t;
	logic clk_sys_i = 0;
	logic sys_rst_i = 1;
	logic psel_i = 0;
	logic penable_i = 0;
	logic pwrite_i = 0;
	logic [7:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0;
	logic timer_input_one_i = 0;
	logic timer_input_two_i = 0;
	wire [31:0] prdata_o;
	wire pready_o, pslverr_o, ch1_out_o, ch1_out_en_o, ch2_out_o, ch2_out_en_o;
	tcc_note_t notes[$];
	tcc_note_t cur;
	int error_cnt = 0;
	int checks_done = 0;
	logic [15:0] seed = 16'h003F;
	logic [7:0] rst_a [6] = '{8'h18, 8'h20, 8'h28, 8'h2C, 8'h30, 8'h34};
	logic [15:0] rst_v [6] = '{0, 0, 0, 16'hFFFF, 0, 0};
	logic [7:0] rnd_a [3] = '{8'h18, 8'h20, 8'h28};
	logic [15:0] rnd_m [3] = '{16'h0F0F, 16'h0033, 16'hFFFF};

	tcc_timer dut (
		.clk_sys_i,
		.sys_rst_i,
		.psel_i,
		.penable_i,
		.pwrite_i,
		.paddr_i,
		.pwdata_i,
		.prdata_o,
		.pready_o,
		.pslverr_o,
		.timer_input_one_i,
		.timer_input_two_i,
		.ch1_out_o,
		.ch1_out_en_o,
		.ch2_out_o,
		.ch2_out_en_o
	);

	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	// ****************
	// helpers
	// ****************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] lo, input logic [31:0] hi, input logic e);
		notes.push_back('{w, e, lo, hi});
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		while (pready_o !== 1'b1) @(posedge clk_sys_i);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 0, 0, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		xfer(1'b0, a, 0, lo, hi, 1'b0);
	endtask

	// order: {ch2 enable, ch2 level, ch1 enable, ch1 level}
	task automatic outs(input logic [3:0] e);
		repeat (2) @(posedge clk_sys_i);
		chk("outputs", e, {ch2_out_en_o, ch2_out_o, ch1_out_en_o, ch1_out_o});
	endtask

	// pulses are long enough to clear the input synchroniser
	task automatic pulse(input int n, input logic [1:0] m);
		repeat (n) begin
			timer_input_one_i <= m[0];
			timer_input_two_i <= m[1];
			repeat (6) @(posedge clk_sys_i);
			timer_input_one_i <= 1'b0;
			timer_input_two_i <= 1'b0;
			repeat (6) @(posedge clk_sys_i);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// reads accept a range so free-running counts can be judged
	always @(posedge clk_sys_i) begin
		if (psel_i && penable_i && pready_o === 1'b1) begin
			cur = notes.pop_front();
			chk("pslverr", cur.e, pslverr_o);
			if (!cur.w) begin
				checks_done++;
				if ($isunknown(prdata_o) || prdata_o < cur.lo ||
					prdata_o > cur.hi) begin
					error_cnt++;
					$display("[FAIL] prdata expected %h..%h seen %h",
						cur.lo, cur.hi, prdata_o);
				end
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		error_cnt++;
		summarize;
	end

	// ****************
	// tests
	// ****************
	initial begin
		repeat (8) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_sys_i);
		foreach (rst_a[k]) rd(rst_a[k], rst_v[k], rst_v[k]);
		$display("reset test done");
		wr(8'h20, 32'h33);
		outs(4'hF);
		wr(8'h20, 32'h11);
		outs(4'hA);
		wr(8'h20, 32'h22);
		outs(4'h0);
		$display("output test done");
		wr(8'h2C, 32'h0);
		wr(8'h24, 32'h1234);
		repeat (20) @(posedge clk_sys_i);
		rd(8'h24, 32'h1234, 32'h1234);
		wr(8'h2C, 32'h5);
		repeat (3) rd(8'h24, 0, 5);
		wr(8'h28, 32'h3);
		wr(8'h2C, 32'h0000_FFFF);
		wr(8'h24, 32'h0);
		repeat (80) @(posedge clk_sys_i);
		rd(8'h24, 19, 22);
		$display("counter test done");
		wr(8'h2C, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(8'h18, (i << 10) | ((i[0] ? 3 : 2) << 8) | (i << 2) | 1);
			wr(8'h20, 32'h0);
			wr(8'h20, 32'h11);
			outs(4'h0);
			wr(8'h24, 32'h100 + i);
			pulse(1 << i, 2'b11);
			wr(8'h24, 32'h200 + i);
			pulse((1 << i) - 1, 2'b11);
			wr(8'h20, 32'h0);
			wr(8'h20, 32'h11);
			pulse((1 << i) - 1, 2'b11);
			rd(8'h30, 32'h100 + i, 32'h100 + i);
			rd(8'h34, 32'h100 + i, 32'h100 + i);
			pulse(1, 2'b11);
			rd(8'h30, 32'h200 + i, 32'h200 + i);
			rd(8'h34, 32'h200 + i, 32'h200 + i);
			// pin one alone must move only the channel mapped to it
			wr(8'h24, 32'h300 + i);
			pulse(1 << i, 2'b01);
			rd(8'h30, 32'h300 + i, 32'h300 + i);
			rd(8'h34, 32'h200 + i, 32'h200 + i);
		end
		$display("capture test done");
		repeat (4) foreach (rnd_a[k]) begin
			seed = lfsr(seed);
			wr(rnd_a[k], {seed, seed});
			rd(rnd_a[k], seed & rnd_m[k], seed & rnd_m[k]);
		end
		xfer(1'b0, 8'h3C, 0, 0, 0, 1'b1);
		xfer(1'b1, 8'h1C, 32'hFFFF_FFFF, 0, 0, 1'b1);
		$display("register test done");
		summarize;
	end
endmodule
